// file: logic/adcc_pkg.sv
`default_nettype none
package adcc_pkg;
   // -------------------------------------------------------------
   // Register map (byte addresses)
   // -------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFF_SC1 = 8'h00;
   localparam logic [7:0] OFF_SC2 = 8'h04;
   localparam logic [7:0] OFF_RH = 8'h08;
   localparam logic [7:0] OFF_RL = 8'h0c;
   localparam logic [7:0] OFF_CVH = 8'h10;
   localparam logic [7:0] OFF_CVL = 8'h14;
   localparam logic [7:0] OFF_CFG = 8'h18;
   localparam logic [7:0] OFF_PCL = 8'h1c;
   localparam logic [7:0] OFF_PCM = 8'h20;
   localparam logic [7:0] OFF_PCT = 8'h24;
   // -------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------
   localparam int SC1_FLAG = 7;
   localparam int SC1_IEN = 6;
   localparam int SC1_CONT = 5;
   localparam int SC2_ACT = 7;
   localparam int SC2_TRG = 6;
   localparam int SC2_CMPE = 5;
   localparam int SC2_GT = 4;
   localparam int CFG_DIV = 5;
   localparam int CFG_MODE = 2;
   localparam int CFG_CLK = 0;
   // -------------------------------------------------------------
   // Encodings and reset values
   // -------------------------------------------------------------
   localparam logic [4:0] CH_OFF = 5'h1f;
   localparam logic [1:0] CLK_BUS = 2'h0;
   localparam logic [1:0] CLK_HALF = 2'h1;
   localparam logic [1:0] CLK_ALT = 2'h2;
   localparam logic [1:0] CLK_ASYNC = 2'h3;
   localparam logic [1:0] MODE_8 = 2'h0;
   localparam logic [1:0] MODE_10 = 2'h2;
   localparam logic [7:0] PC_RESET = 8'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // -------------------------------------------------------------
   // Converter sequencing
   // -------------------------------------------------------------
   localparam logic [3:0] RAW_MSB = 4'ha;
   localparam logic [3:0] STOP_10 = 4'h0;
   localparam logic [3:0] STOP_8 = 4'h2;
   localparam logic [10:0] CODE_FIRST = 11'h400;
   localparam logic [1:0] SETTLE = 2'h3;
   typedef enum logic [1:0] {
      ADCC_IDLE = 2'b00,
      ADCC_SAMPLE = 2'b01,
      ADCC_CONVERT = 2'b10
   } adcc_state_t;
endpackage
`default_nettype wire

// file: logic/adcc_top.sv
`default_nettype none
// Function
// - Disabled in reset or channel all ones
// - Idle after single-conversion completion without new start
// - Raw result 11 bits, 9 in 8-bit
// - 10-bit mode rounds, splits high/low
// - 8-bit mode rounds into low only
// - Store, then set flag, interrupt if enabled
// - Compare active only when compare enabled
// - Four selectable converter clock sources
// - Source codes: bus, half, alternate, async
// - Source resets to plain bus clock
// - Halved source with divider reaches 16
// - Internal async clock generated when selected and channel not all ones
// - Divider ratios 1, 2, 4, 8
// - Divide codes 00..11 map 1..8
// - Analog pin: driver off, pullup off
// - Analog pin: input off, reads zero
// - Middle register: channels 8 to 15
// - Top register: channels 16 to 23
// - Trigger rising edge starts when enabled
// - Edge during conversion is ignored
// - Continuous: only first edge counts
// - Trigger works in every mode
// - Mode selects 10/8 bit; SC2 trigger bit selects sw/hw start
// - Status write starts unless channel off or trigger enabled
module adcc_top #(
   parameter int ASYNC_DIV = 4,
   parameter int SAMPLE_TICKS = 3
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [adcc_pkg::ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [adcc_pkg::ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic cmp_above,
   input wire logic hw_trigger_input,
   input wire logic alternate_clock,
   input wire logic [23:0] port_pin_in,
   output logic [10:0] dac_code,
   output logic sample_hold,
   output logic converter_enable,
   output logic [4:0] channel_out,
   output logic async_clock_on,
   output logic conv_irq,
   output logic [23:0] pin_digital_off,
   output logic [23:0] port_read_value
);
   // -------------------------------------------------------------
   // Parameter checks
   // -------------------------------------------------------------
   if (ASYNC_DIV < 2 || ASYNC_DIV > 16 || SAMPLE_TICKS < 1 || SAMPLE_TICKS > 16) begin : g_chk
      $error("adcc_top: parameter out of range");
   end

   localparam logic [3:0] OSC_LAST = 4'(ASYNC_DIV - 1);
   localparam logic [3:0] SMP_LAST = 4'(SAMPLE_TICKS - 1);

   typedef struct packed {
      logic aw_ok;
      logic [adcc_pkg::ADDR_W-1:0] awa;
      logic w_ok;
      logic [7:0] wd;
      logic ws;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic flag;
      logic ien;
      logic cont;
      logic [4:0] ch;
      logic trg;
      logic cmpe;
      logic gt;
      logic [1:0] div;
      logic [1:0] mode;
      logic [1:0] clk;
      logic [1:0] cvh;
      logic [7:0] cvl;
      logic [1:0] rh;
      logic [7:0] rl;
      logic [23:0] pc;
      adcc_pkg::adcc_state_t st;
      logic [10:0] code;
      logic [3:0] pos;
      logic [3:0] scnt;
      logic [1:0] settle;
      logic half;
      logic [2:0] dcnt;
      logic [3:0] osc;
      logic alt1;
      logic alt2;
      logic alt3;
      logic hw1;
      logic hw2;
      logic hw3;
      logic cmp1;
      logic cmp2;
      logic [23:0] prt1;
      logic [23:0] prt2;
      logic [23:0] prd;
      logic [23:0] pdoff;
      logic irq;
      logic en;
      logic aon;
      logic samp;
   } adcc_s_t;

   adcc_s_t s_q;
   adcc_s_t s_d;
   logic wr_sc1, wr_abort, rd_rl, start, fin, set_flag;
   logic src_tick, converter_clock_tick, async_run, ten, hw_edge, cmp_ok;
   logic [2:0] dmask;
   logic [3:0] stop;
   logic [10:0] code_n;
   logic [9:0] r10, res, cv, val;
   logic [7:0] r8;

   // -------------------------------------------------------------
   // Next-state logic
   // -------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      wr_sc1 = 1'b0;
      wr_abort = 1'b0;
      rd_rl = 1'b0;
      start = 1'b0;
      fin = 1'b0;
      set_flag = 1'b0;
      code_n = s_q.code;
      // Synchronisers for pin-side inputs
      s_d.alt1 = alternate_clock;
      s_d.alt2 = s_q.alt1;
      s_d.alt3 = s_q.alt2;
      s_d.hw1 = hw_trigger_input;
      s_d.hw2 = s_q.hw1;
      s_d.hw3 = s_q.hw2;
      s_d.cmp1 = cmp_above;
      s_d.cmp2 = s_q.cmp1;
      s_d.prt1 = port_pin_in;
      s_d.prt2 = s_q.prt1;
      hw_edge = s_q.hw2 && !s_q.hw3;

      // Write channel: address and data in either order
      if (awvalid && s_q.awready) begin
         s_d.aw_ok = 1'b1;
         s_d.awa = awaddr;
      end
      if (wvalid && s_q.wready) begin
         s_d.w_ok = 1'b1;
         s_d.wd = wdata[7:0];
         s_d.ws = wstrb[0];
      end
      if (s_q.bvalid && bready) begin
         s_d.bvalid = 1'b0;
      end
      if (s_q.aw_ok && s_q.w_ok && !s_q.bvalid) begin
         s_d.aw_ok = 1'b0;
         s_d.w_ok = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = adcc_pkg::RESP_OKAY;
         case (s_q.awa)
            adcc_pkg::OFF_SC1: begin
               if (s_q.ws) begin
                  s_d.ien = s_q.wd[adcc_pkg::SC1_IEN];
                  s_d.cont = s_q.wd[adcc_pkg::SC1_CONT];
                  s_d.ch = s_q.wd[4:0];
                  wr_sc1 = 1'b1;
               end
            end
            adcc_pkg::OFF_SC2: begin
               if (s_q.ws) begin
                  s_d.trg = s_q.wd[adcc_pkg::SC2_TRG];
                  s_d.cmpe = s_q.wd[adcc_pkg::SC2_CMPE];
                  s_d.gt = s_q.wd[adcc_pkg::SC2_GT];
                  wr_abort = 1'b1;
               end
            end
            adcc_pkg::OFF_CFG: begin
               if (s_q.ws) begin
                  s_d.div = s_q.wd[adcc_pkg::CFG_DIV +: 2];
                  s_d.mode = s_q.wd[adcc_pkg::CFG_MODE +: 2];
                  s_d.clk = s_q.wd[adcc_pkg::CFG_CLK +: 2];
                  wr_abort = 1'b1;
               end
            end
            adcc_pkg::OFF_CVH: begin
               if (s_q.ws) begin
                  s_d.cvh = s_q.wd[1:0];
                  wr_abort = 1'b1;
               end
            end
            adcc_pkg::OFF_CVL: begin
               if (s_q.ws) begin
                  s_d.cvl = s_q.wd;
                  wr_abort = 1'b1;
               end
            end
            adcc_pkg::OFF_PCL: if (s_q.ws) s_d.pc[7:0] = s_q.wd;
            adcc_pkg::OFF_PCM: if (s_q.ws) s_d.pc[15:8] = s_q.wd;
            adcc_pkg::OFF_PCT: if (s_q.ws) s_d.pc[23:16] = s_q.wd;
            adcc_pkg::OFF_RH, adcc_pkg::OFF_RL: begin
            end
            default: s_d.bresp = adcc_pkg::RESP_SLVERR;
         endcase
      end
      s_d.awready = !s_d.aw_ok && !s_d.bvalid;
      s_d.wready = !s_d.w_ok && !s_d.bvalid;

      // Read channel
      if (s_q.rvalid && rready) begin
         s_d.rvalid = 1'b0;
      end
      if (arvalid && s_q.arready) begin
         s_d.rvalid = 1'b1;
         s_d.rresp = adcc_pkg::RESP_OKAY;
         s_d.rdata = 32'h0;
         case (araddr)
            adcc_pkg::OFF_SC1: s_d.rdata[7:0] = {s_q.flag, s_q.ien, s_q.cont, s_q.ch};
            adcc_pkg::OFF_SC2: s_d.rdata[7:0] = {s_q.st != adcc_pkg::ADCC_IDLE, s_q.trg, s_q.cmpe, s_q.gt, 4'h0};
            adcc_pkg::OFF_RH: s_d.rdata[1:0] = s_q.rh;
            adcc_pkg::OFF_RL: begin
               s_d.rdata[7:0] = s_q.rl;
               rd_rl = 1'b1;
            end
            adcc_pkg::OFF_CVH: s_d.rdata[1:0] = s_q.cvh;
            adcc_pkg::OFF_CVL: s_d.rdata[7:0] = s_q.cvl;
            adcc_pkg::OFF_CFG: s_d.rdata[7:0] = {1'b0, s_q.div, 1'b0, s_q.mode, s_q.clk};
            adcc_pkg::OFF_PCL: s_d.rdata[7:0] = s_q.pc[7:0];
            adcc_pkg::OFF_PCM: s_d.rdata[7:0] = s_q.pc[15:8];
            adcc_pkg::OFF_PCT: s_d.rdata[7:0] = s_q.pc[23:16];
            default: s_d.rresp = adcc_pkg::RESP_SLVERR;
         endcase
      end
      s_d.arready = !s_d.rvalid;

      async_run = s_q.clk == adcc_pkg::CLK_ASYNC && s_q.ch != adcc_pkg::CH_OFF;
      s_d.aon = async_run;
      s_d.osc = (!async_run || s_q.osc == OSC_LAST) ? 4'h0 : s_q.osc + 4'h1;
      s_d.half = ~s_q.half;
      case (s_q.clk)
         adcc_pkg::CLK_BUS: src_tick = 1'b1;
         adcc_pkg::CLK_HALF: src_tick = s_q.half;
         adcc_pkg::CLK_ALT: src_tick = s_q.alt2 && !s_q.alt3;
         default: src_tick = async_run && s_q.osc == OSC_LAST;
      endcase
      // Divide by 1, 2, 4 or 8
      dmask = 3'((4'h1 << s_q.div) - 4'h1);
      converter_clock_tick = src_tick && ((s_q.dcnt & dmask) == dmask);
      if (src_tick) begin
         s_d.dcnt = s_q.dcnt + 3'h1;
      end

      ten = s_q.mode == adcc_pkg::MODE_10;
      stop = ten ? adcc_pkg::STOP_10 : adcc_pkg::STOP_8;
      s_d.settle = (s_q.settle == 2'h0) ? 2'h0 : s_q.settle - 2'h1;

      // Conversion sequence
      case (s_q.st)
         adcc_pkg::ADCC_IDLE: begin
            if (s_q.trg && hw_edge && s_q.ch != adcc_pkg::CH_OFF) begin
               start = 1'b1;
            end
         end
         adcc_pkg::ADCC_SAMPLE: begin
            if (converter_clock_tick) begin
               if (s_q.scnt == SMP_LAST) begin
                  s_d.st = adcc_pkg::ADCC_CONVERT;
                  s_d.pos = adcc_pkg::RAW_MSB;
                  s_d.code = adcc_pkg::CODE_FIRST;
                  s_d.settle = adcc_pkg::SETTLE;
               end else begin
                  s_d.scnt = s_q.scnt + 4'h1;
               end
            end
         end
         adcc_pkg::ADCC_CONVERT: begin
            if (converter_clock_tick && s_q.settle == 2'h0) begin
               // Keep or drop the trial bit
               if (!s_q.cmp2) begin
                  code_n[s_q.pos] = 1'b0;
               end
               if (s_q.pos == stop) begin
                  fin = 1'b1;
               end else begin
                  code_n[s_q.pos - 4'h1] = 1'b1;
                  s_d.pos = s_q.pos - 4'h1;
                  s_d.settle = adcc_pkg::SETTLE;
               end
               s_d.code = code_n;
            end
         end
         default: s_d.st = adcc_pkg::ADCC_IDLE;
      endcase
      // Rounding with saturation, on the decided code
      r10 = (code_n[10:1] == 10'h3ff) ? 10'h3ff : code_n[10:1] + {9'h0, code_n[0]};
      r8 = (code_n[10:3] == 8'hff) ? 8'hff : code_n[10:3] + {7'h0, code_n[2]};
      res = ten ? r10 : {2'h0, r8};
      cv = ten ? {s_q.cvh, s_q.cvl} : {2'h0, s_q.cvl};
      cmp_ok = !s_q.cmpe || (s_q.gt ? (res >= cv) : (res < cv));
      val = s_q.cmpe ? 10'(res - cv) : res;
      if (fin) begin
         if (cmp_ok) begin
            s_d.rh = ten ? val[9:8] : 2'h0;
            s_d.rl = val[7:0];
            set_flag = 1'b1;
         end
         // Single conversion falls back to idle
         s_d.st = s_q.cont ? adcc_pkg::ADCC_SAMPLE : adcc_pkg::ADCC_IDLE;
         s_d.scnt = 4'h0;
         s_d.code = 11'h0;
      end
      // Writes to SC1, SC2, CFG, CVH and CVL abort the conversion
      if (wr_sc1 || wr_abort) begin
         s_d.st = adcc_pkg::ADCC_IDLE;
         s_d.code = 11'h0;
      end
      if (wr_sc1 && !s_d.trg && s_d.ch != adcc_pkg::CH_OFF) begin
         start = 1'b1;
      end
      if (start) begin
         s_d.st = adcc_pkg::ADCC_SAMPLE;
         s_d.scnt = 4'h0;
         s_d.code = 11'h0;
      end
      // Channel all ones holds it off
      if (s_d.ch == adcc_pkg::CH_OFF) begin
         s_d.st = adcc_pkg::ADCC_IDLE;
         s_d.code = 11'h0;
      end
      if (wr_sc1 || rd_rl) begin
         s_d.flag = 1'b0;
      end
      if (set_flag) begin
         s_d.flag = 1'b1;
      end
      s_d.irq = s_d.flag && s_d.ien;
      s_d.en = s_d.st != adcc_pkg::ADCC_IDLE;
      s_d.samp = s_d.st == adcc_pkg::ADCC_SAMPLE;
      s_d.pdoff = s_q.pc;
      s_d.prd = s_q.prt2 & ~s_q.pc;
   end

   // -------------------------------------------------------------
   // State register
   // -------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= '0;
         s_q.ch <= adcc_pkg::CH_OFF;
         s_q.clk <= adcc_pkg::CLK_BUS;
         s_q.pc <= {3{adcc_pkg::PC_RESET}};
         s_q.st <= adcc_pkg::ADCC_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from the state register
   assign awready = s_q.awready;
   assign wready = s_q.wready;
   assign bresp = s_q.bresp;
   assign bvalid = s_q.bvalid;
   assign arready = s_q.arready;
   assign rdata = s_q.rdata;
   assign rresp = s_q.rresp;
   assign rvalid = s_q.rvalid;
   assign dac_code = s_q.code;
   assign sample_hold = s_q.samp;
   assign converter_enable = s_q.en;
   assign channel_out = s_q.ch;
   assign async_clock_on = s_q.aon;
   assign conv_irq = s_q.irq;
   assign pin_digital_off = s_q.pdoff;
   assign port_read_value = s_q.prd;

   // -------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------
   default clocking adcc_cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   AST_DISABLED:
   assert property (s_q.ch == adcc_pkg::CH_OFF && !wr_sc1 |=> s_q.st == adcc_pkg::ADCC_IDLE && !converter_enable)
   else $error("converter active with channel off");
   AST_IDLE_AFTER_DONE:
   assert property (fin && !s_q.cont && !wr_sc1 |=> s_q.st == adcc_pkg::ADCC_IDLE && !converter_enable)
   else $error("no idle after single conversion");
   AST_SAR_FIRST:
   assert property (s_q.st == adcc_pkg::ADCC_SAMPLE ##1 s_q.st == adcc_pkg::ADCC_CONVERT
      |-> s_q.pos == 4'ha && dac_code == 11'h400)
   else $error("approximation does not start at top bit");
   AST_SAR_LAST:
   assert property (fin |-> s_q.pos == (ten ? 4'h0 : 4'h2))
   else $error("approximation ends at wrong bit");
   AST_ROUND10:
   assert property (fin && ten && !s_q.cmpe |=> ({s_q.rh, s_q.rl} == 10'h3ff)
      || ({s_q.rh, s_q.rl} == $past(code_n[10:1]) + {9'h0, $past(code_n[0])}))
   else $error("10-bit rounding wrong");
   AST_ROUND8:
   assert property (fin && !ten && !s_q.cmpe |=> s_q.rh == 2'h0 && s_q.rl >= $past(code_n[10:3]))
   else $error("8-bit result misplaced");
   AST_FLAG_SET:
   assert property (fin && cmp_ok |=> s_q.flag ##1 (conv_irq == s_q.ien || $changed(s_q.ien) || !s_q.flag))
   else $error("flag or interrupt missing after store");
   AST_CMP_HOLD:
   assert property (fin && !cmp_ok |=> $stable(s_q.rl) && $stable(s_q.rh))
   else $error("result changed on failed compare");
   AST_DIV8:
   assert property (converter_clock_tick && s_q.div == 2'h3 && s_q.clk == adcc_pkg::CLK_BUS
      |=> (!converter_clock_tick || s_q.div != 2'h3 || s_q.clk != adcc_pkg::CLK_BUS) [*7]
      ##1 (converter_clock_tick || s_q.div != 2'h3 || s_q.clk != adcc_pkg::CLK_BUS))
   else $error("divide by eight wrong");
   AST_PINS:
   assert property ((port_read_value & pin_digital_off) == 24'h0)
   else $error("analog pin reads nonzero");
   AST_HW_START:
   assert property (s_q.st == adcc_pkg::ADCC_IDLE && hw_edge && s_q.trg && s_q.ch != adcc_pkg::CH_OFF
      && !wr_sc1 && !wr_abort |=> s_q.st == adcc_pkg::ADCC_SAMPLE)
   else $error("trigger edge did not start");
   AST_HW_IGNORE:
   assert property (s_q.st == adcc_pkg::ADCC_CONVERT && hw_edge && !fin && !wr_sc1 && !wr_abort
      |=> s_q.st == adcc_pkg::ADCC_CONVERT && $stable(s_q.scnt))
   else $error("edge disturbed running conversion");
   AST_SW_START:
   assert property (wr_sc1 && !s_d.trg && s_d.ch != adcc_pkg::CH_OFF |=> s_q.st == adcc_pkg::ADCC_SAMPLE)
   else $error("status write did not start");
endmodule
`default_nettype wire

// file: tb/adcc_analog_model.sv
`default_nettype none
module adcc_analog_model (
   input wire logic aclk,
   input wire logic [10:0] level,
   input wire logic [10:0] dac_code,
   input wire logic fire,
   output logic cmp_above,
   output logic hw_trigger_input
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] hold_q = 3'h0;
   // --------------------------------------------
   // Ideal comparator and trigger source
   // --------------------------------------------
   // Input at or above the trial code
   assign cmp_above = level >= dac_code;
   // Trigger held high a few cycles per request
   always @(posedge aclk) begin
      if (fire) begin
         hold_q <= 3'h5;
      end else if (hold_q != 3'h0) begin
         hold_q <= hold_q - 3'h1;
      end
   end
   assign hw_trigger_input = hold_q != 3'h0;
endmodule
`default_nettype wire

// file: tb/adc_conversion_control_bench.sv
`default_nettype none
module adc_conversion_control_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int ST = 3;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h1;
   logic [10:0] level = 11'h000;
   logic fire = 1'b0, alternate_clock = 1'b0;
   logic [2:0] alt_cnt = 3'h0;
   logic [23:0] port_pin_in = 24'h0;
   logic awready, wready, bvalid, arready, rvalid, cmp_above, hw_trigger_input, sample_hold;
   logic converter_enable, async_clock_on, conv_irq;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [10:0] dac_code;
   logic [4:0] channel_out;
   logic [23:0] pin_digital_off, port_read_value;
   int err_count = 0;
   int num_checks = 0;
   // ------------------------------------------
   // Clock, alternate source, instances
   // ------------------------------------------
   always #4 aclk = ~aclk;
   // Alternate clock: period of eight bus cycles
   always @(posedge aclk) begin
      alt_cnt <= alt_cnt + 3'h1;
      alternate_clock <= alt_cnt[2];
   end
   adcc_top #(.ASYNC_DIV(4), .SAMPLE_TICKS(ST)) u_adcc_top (.aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .cmp_above(cmp_above), .hw_trigger_input(hw_trigger_input),
      .alternate_clock(alternate_clock), .port_pin_in(port_pin_in), .dac_code(dac_code),
      .sample_hold(sample_hold), .converter_enable(converter_enable), .channel_out(channel_out),
      .async_clock_on(async_clock_on), .conv_irq(conv_irq), .pin_digital_off(pin_digital_off),
      .port_read_value(port_read_value));
   adcc_analog_model u_adcc_analog_model (.aclk(aclk), .level(level), .dac_code(dac_code),
      .fire(fire), .cmp_above(cmp_above), .hw_trigger_input(hw_trigger_input));
   // ------------------------------------------
   // Checking and bus tasks
   // ------------------------------------------
   task automatic final_report();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tmo(input int n, input int lim);
      if (n >= lim) begin
         err_count++;
         final_report();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      awaddr <= a;
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 100);
      tmo(n, 100);
      chk(bresp, adcc_pkg::RESP_OKAY);
      bready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 100);
      tmo(n, 100);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      chk(d, e);
   endtask
   task automatic wait_en(input logic v, output int n);
      n = 0;
      while (converter_enable !== v && n < 5000) begin
         @(posedge aclk);
         n++;
      end
      tmo(n, 5000);
   endtask
   task automatic pulse();
      fire <= 1'b1;
      @(posedge aclk);
      fire <= 1'b0;
   endtask
   // Rounded result from an ideal approximation of the level
   function automatic logic [9:0] expect_res(input logic [10:0] lv, input logic ten);
      logic [11:0] t;
      t = ten ? (12'(lv) + 12'h001) >> 1 : (12'(lv[10:2]) + 12'h001) >> 1;
      if (ten && t > 12'h3ff) t = 12'h3ff;
      if (!ten && t > 12'h0ff) t = 12'h0ff;
      return t[9:0];
   endfunction
   // One software conversion per clock and mode case, each clock with one fixed divide
   task automatic convert(input int i);
      logic [1:0] c, v;
      logic ten, ien;
      logic [9:0] e;
      int n, per, bits;
      c = i[1:0];
      v = 2'(i * 3);
      ten = i >= 4;
      ien = i[0];
      level <= (i == 0 || i == 7) ? 11'h7ff : (i == 3) ? 11'h000 : 11'($urandom);
      wr(adcc_pkg::OFF_CFG, {1'b0, v, 1'b0, ten ? adcc_pkg::MODE_10 : adcc_pkg::MODE_8, c});
      wr(adcc_pkg::OFF_SC1, {1'b0, ien, 1'b0, 5'(i)});
      chk(converter_enable, 1'b1);
      chk(async_clock_on, c == adcc_pkg::CLK_ASYNC);
      chk(sample_hold, 1'b1);
      wait_en(1'b0, n);
      per = (c == adcc_pkg::CLK_HALF ? 2 : 1) << v;
      bits = ten ? 11 : 9;
      if (c < 2'h2) chk(n >= (bits - 1) * (per > 4 ? per : 4) && n <= (bits + ST + 4) * (per + 4) + 40, 1);
      e = expect_res(level, ten);
      chk(dac_code, 11'h000);
      chk(sample_hold, 1'b0);
      chk(conv_irq, ien);
      rchk(adcc_pkg::OFF_SC1, {1'b1, ien, 1'b0, 5'(i)});
      rchk(adcc_pkg::OFF_RH, ten ? {6'h00, e[9:8]} : 8'h00);
      rchk(adcc_pkg::OFF_RL, e[7:0]);
      rchk(adcc_pkg::OFF_SC1, {1'b0, ien, 1'b0, 5'(i)});
   endtask
   // ------------------------------------------
   // Main sequence
   // ------------------------------------------
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      logic [23:0] pv;
      int n;
      void'($urandom(57));
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      chk(converter_enable, 1'b0);
      rchk(adcc_pkg::OFF_SC1, 8'h1f);
      rchk(adcc_pkg::OFF_CFG, 8'h00);
      rchk(adcc_pkg::OFF_PCM, adcc_pkg::PC_RESET);
      rchk(adcc_pkg::OFF_PCT, adcc_pkg::PC_RESET);
      rd(8'h28, d, r);
      chk(r, adcc_pkg::RESP_SLVERR);
      chk(d, 32'h0);
      for (int k = 0; k < 2; k++) begin
         pv = k == 0 ? 24'h810180 : 24'($urandom);
         port_pin_in <= 24'($urandom);
         wr(adcc_pkg::OFF_PCL, pv[7:0]);
         wr(adcc_pkg::OFF_PCM, pv[15:8]);
         wr(adcc_pkg::OFF_PCT, pv[23:16]);
         repeat (4) @(posedge aclk);
         chk(pin_digital_off, pv);
         chk(port_read_value, port_pin_in & ~pv);
         rchk(adcc_pkg::OFF_PCM, pv[15:8]);
         rchk(adcc_pkg::OFF_PCT, pv[23:16]);
      end
      for (int i = 0; i < 8; i++) begin
         convert(i);
      end
      wr(adcc_pkg::OFF_CFG, 8'h60);
      wr(adcc_pkg::OFF_SC2, 8'h40);
      wr(adcc_pkg::OFF_SC1, 8'h45);
      chk(converter_enable, 1'b0);
      level <= 11'h2a5;
      pulse();
      wait_en(1'b1, n);
      repeat (40) @(posedge aclk);
      pulse();
      wait_en(1'b0, n);
      repeat (12) @(posedge aclk);
      chk(converter_enable, 1'b0);
      rchk(adcc_pkg::OFF_RL, expect_res(11'h2a5, 1'b0));
      // Continuous run launched by one trigger edge
      wr(adcc_pkg::OFF_SC1, 8'h65);
      pulse();
      repeat (300) @(posedge aclk);
      chk(converter_enable, 1'b1);
      chk(conv_irq, 1'b1);
      rchk(adcc_pkg::OFF_SC1, 8'he5);
      wr(adcc_pkg::OFF_SC2, 8'h00);
      // Compare: lower limit passes, upper limit holds the result
      level <= 11'h300;
      wr(adcc_pkg::OFF_CVL, 8'h40);
      wr(adcc_pkg::OFF_SC2, 8'h30);
      for (int k = 0; k < 2; k++) begin
         wr(adcc_pkg::OFF_SC1, 8'h05);
         wait_en(1'b0, n);
         rchk(adcc_pkg::OFF_SC1, {k == 0, 7'h05});
         rchk(adcc_pkg::OFF_RL, 8'(expect_res(11'h300, 1'b0) - 10'h040));
         wr(adcc_pkg::OFF_SC2, 8'h20);
      end
      wr(adcc_pkg::OFF_SC1, 8'h1f);
      repeat (4) @(posedge aclk);
      chk(converter_enable, 1'b0);
      chk(channel_out, adcc_pkg::CH_OFF);
      final_report();
   end
endmodule
`default_nettype wire
